// file: core/tlb_dirty_map.vh
/*
  Address map, field positions, reset values and codes for the dirty-page
  fault and translation-array access block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef TLB_DIRTY_MAP_VH
`define TLB_DIRTY_MAP_VH

// ----------------------------------------------------------------
// AXI4-Lite register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_STATUS_WORD 8'h04
`define OFS_SAVED_STATUS 8'h08
`define OFS_SAVED_PC 8'h0C
`define OFS_EVENT_CODE 8'h10
`define OFS_FAULT_ADDRESS 8'h14
`define OFS_TRANS_HIGH 8'h18
`define OFS_TRANS_LOW 8'h1C
`define OFS_VECTOR_BASE 8'h20
`define OFS_FAULT_TARGET 8'h24
`define OFS_ARRAY_ADDR 8'h28
`define OFS_ARRAY_DATA 8'h2C
`define OFS_ARRAY_CMD 8'h30
`define OFS_LOAD_CMD 8'h34

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_IX_BIT 2
`define CTL_RC_LSB 6
`define SR_MD_BIT 30
`define SR_RB_BIT 29
`define SR_BL_BIT 28
`define TAG_V_BIT 8
`define DATA_D_BIT 2
`define DATA_V_BIT 8
`define ASSOC_BIT 7

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define EVT_DIRTY 12'h080
`define VEC_OFFSET 32'h00000100
`define AREA_TAG 8'hF2
`define AREA_DATA 8'hF3
`define SR_RESET 32'h70000000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: core/tlb_dirty_fault.v
/*
  Dirty-page fault detection with fault context capture, translation
  tag/data arrays (32 entries x 4 ways) and their mapped access path.
  Assumes a core pipeline presenting one write lookup per pulse and
  software on AXI4-Lite; single clock, asynchronous active-high reset.
*/
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tlb_dirty_map.vh"

// How it works
// - Write hitting valid entry with clear dirty bit raises dirty-page fault.
// - Fault loads faulting page number into translation_high.
// - Fault stores the whole faulting address in fault_address.
// - Fault writes event code 080 into exception_event_code.
// - saved_pc gets instruction address, or delayed branch address in slot.
// - Status word at fault time is copied into saved_status.
// - Fault sets privilege_level, exception_block, bank_select to one.
// - Faulting way number goes into replace_way_counter.
// - Fault target is vector_base plus 100.
// - Array accesses work only in privileged mode.
// - Tag array decodes at F2xxxxxx, data array at F3xxxxxx.
// - Array accesses are longword only; partial strobes are refused.
// - Data-array accesses also reach the entry valid flags.
// - Tag access: index bits 16-12, way bits 9-8, area F2.
// - With index_hash_mode, index is address bits XOR space tag.
// - Tag read returns page number, valid flag, space tag.
// - Tag write stores page number, valid flag, space tag.
// - Data access: index bits 16-12, way bits 9-8, area F3.
// - Data access moves the one longword of selected entry and way.
// - Associative tag write updates the valid flag of every matching way, else nothing.
module tlb_dirty_fault (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Core lookup request
  input wire lookupValid,
  input wire [31:0] lookupAddr,
  input wire [31:0] lookupPc,
  input wire [31:0] branchPc,
  input wire inDelaySlot,
  // Fault result
  output reg faultTaken,
  output reg [31:0] faultTarget,
  // AXI4-Lite write
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Software-visible registers
  reg [31:0] control;
  reg [31:0] statusWord;
  reg [31:0] savedStatus;
  reg [31:0] savedPc;
  reg [31:0] eventCode;
  reg [31:0] faultAddress;
  reg [31:0] transHigh;
  reg [31:0] transLow;
  reg [31:0] vectorBase;
  reg [31:0] arrayAddr;
  reg [31:0] arrayData;
  // Translation arrays: 32 entries by 4 ways
  reg [31:0] tagMem [0:127];
  reg [31:0] dataMem [0:127];
  // Write channel holding registers
  reg [7:0] awAddrHeld;
  reg awHave;
  reg [31:0] wDataHeld;
  reg [3:0] wStrbHeld;
  reg wHave;
  // Reset loop index
  integer i;

  // ----------------------------------------------------------------
  // Lookup: index, per-way hit, dirty check
  // ----------------------------------------------------------------
  // Current space tag and lookup index
  wire ixMode = control[`CTL_IX_BIT];
  wire [7:0] curAsid = transHigh[7:0];
  wire [4:0] lkIndex = ixMode ? (lookupAddr[16:12] ^ curAsid[4:0])
                              : lookupAddr[16:12];
  // Per-way hit and clean state
  wire [3:0] wayHit;
  wire [3:0] wayClean;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gWay
      // Way number as a constant slice
      localparam [31:0] WAY_ID = g;
      wire [31:0] tg = tagMem[{lkIndex, WAY_ID[1:0]}];
      wire [31:0] dt = dataMem[{lkIndex, WAY_ID[1:0]}];
      assign wayHit[g] = tg[`TAG_V_BIT] && tg[31:17] == lookupAddr[31:17]
        && tg[11:10] == lookupAddr[11:10] && tg[7:0] == curAsid;
      assign wayClean[g] = ~dt[`DATA_D_BIT];
    end
  endgenerate
  // Lowest hitting way wins
  wire [1:0] hitWay = wayHit[0] ? 2'h0 : wayHit[1] ? 2'h1 :
                      wayHit[2] ? 2'h2 : 2'h3;
  // Fault only while exceptions are unmasked
  wire dirtyFault = lookupValid && !statusWord[`SR_BL_BIT]
    && |wayHit && wayClean[hitWay];

  // ----------------------------------------------------------------
  // Mapped array access decode
  // ----------------------------------------------------------------
  // Area select, index and slot
  wire isTag = arrayAddr[31:24] == `AREA_TAG;
  wire isData = arrayAddr[31:24] == `AREA_DATA;
  wire [4:0] arIndex = ixMode ? (arrayAddr[16:12] ^ curAsid[4:0])
                              : arrayAddr[16:12];
  wire [6:0] arSlot = {arIndex, arrayAddr[9:8]};
  // Entry load index follows the same hashing as the lookup
  wire [4:0] ldIndex = ixMode ? (transHigh[16:12] ^ curAsid[4:0])
                              : transHigh[16:12];
  // Array access needs privileged mode
  wire privOk = statusWord[`SR_MD_BIT];
  // Associative match against the staged data word
  wire assoc = arrayAddr[`ASSOC_BIT];
  wire [3:0] assocHit;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gAssoc
      localparam [31:0] WAY_ID = g;
      wire [31:0] tg = tagMem[{arIndex, WAY_ID[1:0]}];
      assign assocHit[g] = tg[31:17] == arrayData[31:17]
        && tg[11:10] == arrayData[11:10] && tg[7:0] == arrayData[7:0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Write path decode
  // ----------------------------------------------------------------
  // Write completes once address and data are both held
  wire doWrite = awHave && wHave && !bvalid;
  wire fullWord = wStrbHeld == 4'hF;
  wire wrKnown = awAddrHeld <= `OFS_LOAD_CMD && awAddrHeld[1:0] == 2'b00
    && awAddrHeld != `OFS_FAULT_TARGET;
  wire arrayCmd = doWrite && fullWord && awAddrHeld == `OFS_ARRAY_CMD;
  wire arrayOk = privOk && (isTag || isData);
  wire loadCmd = doWrite && fullWord && awAddrHeld == `OFS_LOAD_CMD;

  // Register read mux
  reg [31:0] readMux;
  reg readOk;
  always @* begin
    readOk = 1'b1;
    case (araddr)
      `OFS_CONTROL: readMux = control;
      `OFS_STATUS_WORD: readMux = statusWord;
      `OFS_SAVED_STATUS: readMux = savedStatus;
      `OFS_SAVED_PC: readMux = savedPc;
      `OFS_EVENT_CODE: readMux = eventCode;
      `OFS_FAULT_ADDRESS: readMux = faultAddress;
      `OFS_TRANS_HIGH: readMux = transHigh;
      `OFS_TRANS_LOW: readMux = transLow;
      `OFS_VECTOR_BASE: readMux = vectorBase;
      `OFS_FAULT_TARGET: readMux = faultTarget;
      `OFS_ARRAY_ADDR: readMux = arrayAddr;
      `OFS_ARRAY_DATA: readMux = arrayData;
      default: begin
        readMux = 32'h00000000;
        readOk = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld <= 32'h00000000;
      wStrbHeld <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      // Write address channel
      if (awvalid && awready) begin
        awAddrHeld <= awaddr;
        awHave <= 1'b1;
        awready <= 1'b0;
      end
      // Write data channel
      if (wvalid && wready) begin
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
        wHave <= 1'b1;
        wready <= 1'b0;
      end
      // Response once both halves are held
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= (wrKnown && fullWord
                  && !(awAddrHeld == `OFS_ARRAY_CMD && !arrayOk))
                 ? `RESP_OKAY : `RESP_SLVERR;
        awHave <= 1'b0;
        wHave <= 1'b0;
      end
      // Reopen the write channels
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      // Read address taken, answer next cycle
      if (arvalid && arready) begin
        rdata <= readMux;
        rresp <= readOk ? `RESP_OKAY : `RESP_SLVERR;
        rvalid <= 1'b1;
        arready <= 1'b0;
      end
      // Read answer accepted
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers, fault capture and array access
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      control <= 32'h00000000;
      statusWord <= `SR_RESET;
      savedStatus <= 32'h00000000;
      savedPc <= 32'h00000000;
      eventCode <= 32'h00000000;
      faultAddress <= 32'h00000000;
      transHigh <= 32'h00000000;
      transLow <= 32'h00000000;
      vectorBase <= 32'h00000000;
      arrayAddr <= 32'h00000000;
      arrayData <= 32'h00000000;
      faultTaken <= 1'b0;
      faultTarget <= 32'h00000000;
      // Clear both arrays
      for (i = 0; i < 128; i = i + 1) begin
        tagMem[i] <= 32'h00000000;
        dataMem[i] <= 32'h00000000;
      end
    end else begin
      // One-cycle fault pulse
      faultTaken <= dirtyFault;
      // Software register writes
      if (doWrite && fullWord) begin
        case (awAddrHeld)
          `OFS_CONTROL: control <= wDataHeld;
          `OFS_STATUS_WORD: statusWord <= wDataHeld;
          `OFS_SAVED_STATUS: savedStatus <= wDataHeld;
          `OFS_SAVED_PC: savedPc <= wDataHeld;
          `OFS_EVENT_CODE: eventCode <= wDataHeld;
          `OFS_FAULT_ADDRESS: faultAddress <= wDataHeld;
          `OFS_TRANS_HIGH: transHigh <= wDataHeld;
          `OFS_TRANS_LOW: transLow <= wDataHeld;
          `OFS_VECTOR_BASE: vectorBase <= wDataHeld;
          `OFS_ARRAY_ADDR: arrayAddr <= wDataHeld;
          `OFS_ARRAY_DATA: arrayData <= wDataHeld;
          default: ;
        endcase
      end
      // Entry load: translation_high/low into the replace way
      if (loadCmd) begin
        tagMem[{ldIndex, control[`CTL_RC_LSB+1:`CTL_RC_LSB]}]
          <= {transHigh[31:9], transLow[`DATA_V_BIT], transHigh[7:0]};
        dataMem[{ldIndex, control[`CTL_RC_LSB+1:`CTL_RC_LSB]}]
          <= transLow;
      end
      // Mapped array command: bit 0 of data selects write
      if (arrayCmd && arrayOk) begin
        // Write: associative, plain tag or data entry
        if (wDataHeld[0]) begin
          if (isTag && assoc) begin
            if (assocHit[0]) tagMem[{arIndex, 2'h0}][`TAG_V_BIT]
              <= arrayData[`TAG_V_BIT];
            if (assocHit[1]) tagMem[{arIndex, 2'h1}][`TAG_V_BIT]
              <= arrayData[`TAG_V_BIT];
            if (assocHit[2]) tagMem[{arIndex, 2'h2}][`TAG_V_BIT]
              <= arrayData[`TAG_V_BIT];
            if (assocHit[3]) tagMem[{arIndex, 2'h3}][`TAG_V_BIT]
              <= arrayData[`TAG_V_BIT];
          end else if (isTag) begin
            tagMem[arSlot] <= {arrayData[31:10], 1'b0,
              arrayData[`TAG_V_BIT], arrayData[7:0]};
          end else begin
            dataMem[arSlot] <= arrayData;
            tagMem[arSlot][`TAG_V_BIT] <= arrayData[`DATA_V_BIT];
          end
        end else if (isTag) begin
          arrayData <= {tagMem[arSlot][31:10], 1'b0,
            tagMem[arSlot][`TAG_V_BIT], tagMem[arSlot][7:0]};
        end else begin
          arrayData <= {dataMem[arSlot][31:9],
            tagMem[arSlot][`TAG_V_BIT], dataMem[arSlot][7:0]};
        end
      end
      // Fault capture has priority over software writes
      if (dirtyFault) begin
        transHigh <= {lookupAddr[31:10], 2'b00, curAsid};
        faultAddress <= lookupAddr;
        eventCode <= {20'h00000, `EVT_DIRTY};
        savedPc <= inDelaySlot ? branchPc : lookupPc;
        savedStatus <= statusWord;
        statusWord <= statusWord | (32'h1 << `SR_MD_BIT)
          | (32'h1 << `SR_BL_BIT) | (32'h1 << `SR_RB_BIT);
        control[`CTL_RC_LSB+1:`CTL_RC_LSB] <= hitWay;
        faultTarget <= vectorBase + `VEC_OFFSET;
      end
    end
  end

endmodule // tlb_dirty_fault

// file: tb/tlb_dirty_fault_properties.sv
/* Port checker for the dirty fault block.
   Bound to the top module; single clock, reset active high. */
`timescale 1ns/1ps
`include "tlb_dirty_map.vh"
module tlb_dirty_fault_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fault link
  input wire lookupValid,
  input wire faultTaken,
  input wire [31:0] faultTarget,
  // Register bus
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [3:0] wstrb,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // Write address and data taken together
  wire wTake = awvalid && awready && wvalid && wready;

  property p_pulse; faultTaken |=> !faultTaken; endproperty
  a_pulse: assert property (p_pulse) else $error("long fault pulse");
  property p_cause; faultTaken |-> $past(lookupValid); endproperty
  a_cause: assert property (p_cause) else $error("fault without lookup");
  property p_hold; $changed(faultTarget) |-> faultTaken; endproperty
  a_hold: assert property (p_hold) else $error("target moved");
  property p_rlat; arvalid && arready |=> rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("late read answer");
  property p_wlat; wTake |-> ##[1:3] bvalid; endproperty
  a_wlat: assert property (p_wlat) else $error("late write answer");
  property p_strb;
    wTake && wstrb != 4'hF |-> ##[1:3] bvalid && bresp == `RESP_SLVERR;
  endproperty
  a_strb: assert property (p_strb) else $error("partial write taken");
  property p_busy; bvalid |-> !awready && !wready; endproperty
  a_busy: assert property (p_busy) else $error("second write taken");
  property p_rdone; rvalid && rready |=> !rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read answer repeated");
endmodule // tlb_dirty_fault_properties

bind tlb_dirty_fault tlb_dirty_fault_properties i_props (.clk, .rst,
  .lookupValid, .faultTaken, .faultTarget, .awvalid, .awready, .wvalid,
  .wready, .wstrb, .bresp, .bvalid, .bready, .arvalid, .arready, .rvalid,
  .rready);

// file: tb/core_pipe_model.sv
/* Core pipeline stand-in: one write lookup per fire pulse.
   Assumes fire is driven just after clock edges. */
`timescale 1ns/1ps
module core_pipe_model (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bench command
  input wire fire,
  input wire [31:0] va,
  input wire [31:0] pc,
  input wire [31:0] bpc,
  input wire slot,
  // Lookup toward the block
  output reg lookupValid = 1'b0,
  output reg [31:0] lookupAddr = 32'h0,
  output reg [31:0] lookupPc = 32'h0,
  output reg [31:0] branchPc = 32'h0,
  output reg inDelaySlot = 1'b0
);
  // One-cycle lookup; idle lines toggle so stale values never match
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lookupValid <= 1'b0;
    end else begin
      lookupValid <= fire;
      lookupAddr <= fire ? va : ~lookupAddr;
      lookupPc <= fire ? pc : ~lookupPc;
      branchPc <= fire ? bpc : ~branchPc;
      inDelaySlot <= fire ? slot : ~inDelaySlot;
    end
  end
endmodule // core_pipe_model

// file: tb/tlb_dirty_fault_tb.sv
/* Self-checking bench for the dirty fault block.
   Assumes the map header on the include path. */
`timescale 1ns/1ps
`include "tlb_dirty_map.vh"
module tlb_dirty_fault_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg fire = 1'b0, slot = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  reg bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [31:0] va = 32'h0, pc = 32'h0, bpc = 32'h0, wdata = 32'h0;
  reg [31:0] seed = 32'h7E31DA0D, vector_base, tagw, arr;
  reg [7:0] awaddr = 8'h0, araddr = 8'h0;
  reg [3:0] wstrb = 4'h0;
  reg [1:0] way;
  wire lookupValid, inDelaySlot, faultTaken, awready, wready;
  wire bvalid, arready, rvalid;
  wire [31:0] lookupAddr, lookupPc, branchPc, faultTarget, rdata;
  wire [1:0] bresp, rresp;
  reg [33:0] rq[$], wq[$], fq[$];
  int miscompares = 0, checkCount = 0, i;

  // Clock
  always #10 clk = ~clk;

  tlb_dirty_fault i_dut (.clk, .rst, .lookupValid, .lookupAddr, .lookupPc,
    .branchPc, .inDelaySlot, .faultTaken, .faultTarget, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  core_pipe_model i_core (.clk, .rst, .fire, .va, .pc, .bpc, .slot,
    .lookupValid, .lookupAddr, .lookupPc, .branchPc, .inDelaySlot);

  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input [33:0] seen, input [33:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Bus write; expected response noted for the scoreboard
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s = 4'hF,
                    input [1:0] e = 2'b00);
    @(posedge clk);
    wq.push_back(e);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  // Bus read; expected data and response noted
  task automatic rd(input [7:0] a, input [31:0] d, input [1:0] e = 2'b00);
    @(posedge clk);
    rq.push_back({e, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // One lookup through the core stand-in
  task automatic kick();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Scoreboard: oldest note against each result
  always @(posedge clk) begin
    if (bvalid && bready) chk(bresp, wq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (faultTaken) chk(faultTarget, fq.size() ? fq.pop_front() : 'x);
  end

  // Hang guard
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_STATUS_WORD, `SR_RESET);
    rd(8'hFC, 32'h0, `RESP_SLVERR);
    wr(`OFS_FAULT_TARGET, 32'h1, 4'hF, `RESP_SLVERR);
    wr(`OFS_VECTOR_BASE, 32'h5, 4'h3, `RESP_SLVERR);
    vector_base = rnd();
    va = rnd();
    way = va[1:0];
    tagw = {va[31:10], 2'b01, 8'h5A};
    arr = {8'hF2, 7'h0, va[16:12], 2'b00, way, 8'h00};
    wr(`OFS_VECTOR_BASE, vector_base);
    wr(`OFS_TRANS_HIGH, 32'h5A);
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_ARRAY_ADDR, 32'hF4000000);
    wr(`OFS_ARRAY_CMD, 32'h1, 4'hF, `RESP_SLVERR);
    wr(`OFS_ARRAY_ADDR, arr);
    wr(`OFS_ARRAY_DATA, tagw);
    wr(`OFS_ARRAY_CMD, 32'h1);
    wr(`OFS_ARRAY_DATA, 32'h0);
    wr(`OFS_ARRAY_CMD, 32'h0);
    rd(`OFS_ARRAY_DATA, tagw);
    wr(`OFS_ARRAY_ADDR, arr | 32'h01000000);
    wr(`OFS_ARRAY_DATA, 32'h100);
    wr(`OFS_ARRAY_CMD, 32'h1);
    for (i = 1; i >= 0; i--) begin
      wr(`OFS_STATUS_WORD, 32'h40000000);
      slot <= i[0];
      pc <= rnd();
      bpc <= rnd();
      fq.push_back({2'b00, vector_base + `VEC_OFFSET});
      kick();
      rd(`OFS_EVENT_CODE, {20'h0, `EVT_DIRTY});
      rd(`OFS_FAULT_ADDRESS, va);
      rd(`OFS_TRANS_HIGH, {va[31:10], 10'h05A});
      rd(`OFS_SAVED_PC, slot ? bpc : pc);
      rd(`OFS_SAVED_STATUS, 32'h40000000);
      rd(`OFS_STATUS_WORD, `SR_RESET);
      rd(`OFS_CONTROL, {way, 6'h0});
      kick();
    end
    wr(`OFS_TRANS_LOW, 32'h104);
    wr(`OFS_LOAD_CMD, 32'h0);
    wr(`OFS_LOAD_CMD, 32'h0);
    wr(`OFS_STATUS_WORD, 32'h40000000);
    kick();
    wr(`OFS_ARRAY_ADDR, arr | 32'h01000000);
    wr(`OFS_ARRAY_CMD, 32'h0);
    rd(`OFS_ARRAY_DATA, 32'h104);
    for (i = 0; i < 2; i++) begin
      wr(`OFS_ARRAY_ADDR, arr | 32'h80);
      wr(`OFS_ARRAY_DATA, tagw ^ (i ? 32'h100 : 32'h101));
      wr(`OFS_ARRAY_CMD, 32'h1);
      wr(`OFS_ARRAY_ADDR, arr);
      wr(`OFS_ARRAY_CMD, 32'h0);
      rd(`OFS_ARRAY_DATA, tagw ^ (i ? 32'h100 : 32'h0));
    end
    wr(`OFS_CONTROL, 32'h4);
    wr(`OFS_ARRAY_ADDR, arr ^ 32'h0001A000);
    wr(`OFS_ARRAY_CMD, 32'h0);
    rd(`OFS_ARRAY_DATA, tagw ^ 32'h100);
    wr(`OFS_STATUS_WORD, 32'h0);
    wr(`OFS_ARRAY_CMD, 32'h0, 4'hF, `RESP_SLVERR);
    kick();
    chk(fq.size(), 0);
    report_and_stop();
  end
endmodule // tlb_dirty_fault_tb
